// ### clock_divider.sv
// Synchroniser and divider for the 32.768 kHz capture-pin clock.
// Assumes the pin is far slower than the system clock; it is sampled, never
// used as a clock, so no second domain exists.
`timescale 1ns/10ps
module clock_divider
  import timer_module_pkg::*;
#(
  parameter int DIVIDE = CLOCK_DIVIDE
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Control and slow clock pin
  input wire logic i_run,
  input wire logic i_capture_pin_zero,
  // One-cycle pulse once a second
  output logic o_second
);

  localparam int CW = $clog2(DIVIDE);

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic last;
    logic [CW-1:0] count;
    logic second;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic rise;

  always_comb begin
    s_d = s_q;
    s_d.sync_first = i_capture_pin_zero;
    s_d.sync_second = s_q.sync_first;
    s_d.last = s_q.sync_second;
    s_d.second = 1'b0;
    rise = s_q.sync_second & ~s_q.last;
    if (!i_run) begin
      s_d.count = '0;
    end else if (rise) begin
      if (s_q.count == CW'(DIVIDE - 1)) begin
        s_d.count = '0;
        s_d.second = 1'b1;
      end else begin
        s_d.count = s_q.count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_second = s_q.second;

  property p_second_after_edge;
    @(posedge i_clock) disable iff (!i_nrst)
    o_second |-> $past(rise && i_run);
  endproperty
  a_second_after_edge: assert property (p_second_after_edge) else $error("second without edge");

endmodule

// ### general_timer_32bit_modes_tb.sv
// Testbench for the dual-half timer: reset state, joined one-shot and
// periodic runs, load rewrite, debug stall, split config, real-time clock.
// Assumes the far-side model supplies the slow pin clock.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module general_timer_32bit_modes_tb;
  import timer_module_pkg::*;
  localparam int DIV = 4;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic i_debug_halt = 1'b0;
  logic pin;
  logic pin_run = 1'b0;
  logic [31:0] o_rdata;
  logic o_interrupt;
  logic o_converter_trigger;
  logic [31:0] d;
  logic [31:0] d2;
  int failures = 0;
  int n_tests = 0;
  int pulses;
  int seen;
  int t;

  // 125 MHz clock
  always #4 i_clock = ~i_clock;

  timer_module_top #(.DIVIDE(DIV)) DUT (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_debug_halt(i_debug_halt), .i_capture_pin_zero(pin),
    .o_interrupt(o_interrupt), .o_converter_trigger(o_converter_trigger));

  timer_far_side far (.i_clock(i_clock), .i_run(pin_run), .o_capture_pin_zero(pin),
    .i_converter_trigger(o_converter_trigger), .o_pulses(pulses));

  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One-cycle strobes; a gap edge between calls keeps drivers single
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask

  // Bounded waits; running out counts as a failure
  task automatic wait_int(input logic lvl, input int lim);
    t = 0;
    while (o_interrupt !== lvl) begin
      @(posedge i_clock);
      t++;
      if (t > lim) begin
        failures++;
        end_of_test();
      end
    end
  endtask

  task automatic wait_pulse(input int lim);
    t = 0;
    seen = pulses;
    while (pulses == seen) begin
      @(posedge i_clock);
      #1;
      t++;
      if (t > lim) begin
        failures++;
        end_of_test();
      end
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_nrst <= 1'b1;
    chk_rd(OFF_WIDTH_CONFIG, 32'h0); // config cleared
    chk_rd(OFF_CONTROL, 32'h0); // control cleared
    chk_rd(OFF_FIRST_COUNT, 32'hffff_ffff); // joined count
    chk_rd(OFF_SECOND_LOAD, {16'h0, HALF_LOAD_RESET}); // load reset
    chk_rd(OFF_FIRST_PRESCALE, {24'h0, PRESCALE_RESET}); // prescale
    chk_rd(OFF_SECOND_PRESCALE, 32'h0); // prescale
    chk_rd(8'hfc, 32'h0); // unmapped reads zero
    // Joined one-shot, trigger off, loaded while running
    wr(OFF_FIRST_MODE, {30'h0, HALF_ONE_SHOT});
    wr(OFF_INT_MASK, 32'h1);
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_FIRST_LOAD, 32'h5);
    chk_rd(OFF_SECOND_LOAD, 32'h0); // upper half to second load
    wait_int(1'b1, 20);
    chk_rd(OFF_CONTROL, 32'h0); // enable cleared
    chk_rd(OFF_FIRST_COUNT, 32'h5); // reloaded and stopped
    chk_rd(OFF_RAW_STATUS, 32'h1); // raw time-out
    chk_rd(OFF_MASKED_STATUS, 32'h1); // masked time-out
    `CHK(pulses, 0) // no trigger while disabled
    wr(OFF_INT_CLEAR, 32'h1);
    chk_rd(OFF_RAW_STATUS, 32'h0); // cleared by software
    `CHK(o_interrupt, 1'b0) // follows masked flags
    // Periodic with trigger: load N gives N+1 cycles
    wr(OFF_FIRST_MODE, {30'h0, HALF_PERIODIC});
    wr(OFF_CONTROL, 32'h21);
    wr(OFF_FIRST_LOAD, 32'h9);
    wait_pulse(40);
    wait_pulse(40);
    `CHK(t, 11 - 1) // reload period
    wr(OFF_FIRST_LOAD, 32'h40);
    rd(OFF_FIRST_COUNT, d);
    `CHK(d, 32'h40 - 32'h1) // rewrite reloads
    // Debug stall freezes the count
    wr(OFF_CONTROL, 32'h23);
    @(posedge i_clock);
    i_debug_halt <= 1'b1;
    rd(OFF_FIRST_COUNT, d);
    repeat (5) @(posedge i_clock);
    rd(OFF_FIRST_COUNT, d2);
    `CHK(d2, d) // frozen in halt
    @(posedge i_clock);
    i_debug_halt <= 1'b0;
    repeat (5) @(posedge i_clock);
    rd(OFF_FIRST_COUNT, d2);
    `CHK(d2 !== d, 1'b1) // resumes after halt
    // Split operation and prescale
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_INT_CLEAR, 32'h109);
    wr(OFF_WIDTH_CONFIG, {29'h0, CFG_SPLIT});
    chk_rd(OFF_WIDTH_CONFIG, 32'h4); // split code
    wr(OFF_FIRST_PRESCALE, 32'h3);
    chk_rd(OFF_FIRST_PRESCALE, 32'h3); // 8-bit prescale
    // Split one-shot on the first half: prescale 3 gives four clocks a step
    wr(OFF_FIRST_MODE, {30'h0, HALF_ONE_SHOT});
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_FIRST_LOAD, 32'h0007_0002);
    wait_int(1'b1, 40);
    `CHK(t inside {[9:14]}, 1'b1) // prescaled steps
    chk_rd(OFF_CONTROL, 32'h0); // split one-shot stops
    chk_rd(OFF_FIRST_COUNT, 32'h2); // first half alone
    chk_rd(OFF_SECOND_LOAD, 32'h0); // split load stays apart
    wr(OFF_INT_CLEAR, 32'h1);
    // Real-time clock, halted but overridden
    wr(OFF_WIDTH_CONFIG, {29'h0, CFG_JOINED_CLOCK});
    chk_rd(OFF_FIRST_COUNT, CLOCK_START); // starts at one
    wr(OFF_FIRST_MATCH, 32'h2);
    wr(OFF_INT_MASK, 32'h8);
    i_debug_halt <= 1'b1;
    wr(OFF_CONTROL, 32'h13);
    // Start the pin once the divider is armed so no early edge is lost
    pin_run <= 1'b1;
    wait_int(1'b1, 40000);
    `CHK(t inside {[26000:30000]}, 1'b1) // two ticks of DIV edges
    chk_rd(OFF_FIRST_COUNT, 32'h0); // rolled over at match
    chk_rd(OFF_MASKED_STATUS, 32'h8); // masked match
    chk_rd(OFF_RAW_STATUS, 32'h8); // raw match
    wr(OFF_INT_CLEAR, 32'h8);
    chk_rd(OFF_RAW_STATUS, 32'h0); // raw cleared
    chk_rd(OFF_MASKED_STATUS, 32'h0); // masked cleared
    `CHK(o_interrupt, 1'b0) // interrupt dropped
    end_of_test();
  end
endmodule

// ### half_prescaler.sv
// One 8-bit prescaler for a counter half in split operation.
// Assumes i_run is high only while the half counts in one-shot or periodic mode.
`timescale 1ns/10ps
module half_prescaler
  import timer_module_pkg::*;
#(
  parameter int WIDTH = PRESCALE_WIDTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Control
  input wire logic i_run,
  input wire logic i_reload,
  input wire logic [WIDTH-1:0] i_prescale,
  // Step strobe for the half
  output logic o_tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } state_type;

  state_type s_q;
  state_type s_d;

  // A prescale of P gives one step every P+1 clocks
  always_comb begin
    s_d = s_q;
    o_tick = 1'b0;
    if (i_reload) begin
      s_d.count = i_prescale;
    end else if (i_run) begin
      if (s_q.count == '0) begin
        o_tick = 1'b1;
        s_d.count = i_prescale;
      end else begin
        s_d.count = s_q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '{count: WIDTH'(PRESCALE_RESET)};
    end else begin
      s_q <= s_d;
    end
  end

  property p_tick_at_zero;
    @(posedge i_clock) disable iff (!i_nrst)
    o_tick |-> (i_run && !i_reload && s_q.count == '0);
  endproperty
  a_tick_at_zero: assert property (p_tick_at_zero) else $error("prescaler tick off zero");

endmodule

// ### timer_far_side.sv
// Far-side model: slow crystal on the even capture pin, toggling only while i_run is high,
// and a counter of converter trigger pulses. Assumes one 8 ns system clock.
`timescale 1ns/10ps
module timer_far_side (
  // Clock and control
  input wire logic i_clock,
  input wire logic i_run,
  // Pin and trigger
  output logic o_capture_pin_zero,
  input wire logic i_converter_trigger,
  output int o_pulses
);
  // 32.768 kHz source
  // Gated low while idle so a stale level never looks like an edge
  initial begin
    o_capture_pin_zero = 1'b0;
    forever begin
      #15258.79;
      o_capture_pin_zero = i_run ? ~o_capture_pin_zero : 1'b0;
    end
  end
  initial o_pulses = 0;
  always @(posedge i_clock) begin
    if (i_converter_trigger === 1'b1) begin
      o_pulses <= o_pulses + 1;
    end
  end
endmodule

// ### timer_module_pkg.sv
// Package for the dual-half general timer: register offsets, field positions,
// reset values, configuration codes and the real-time-clock divide count.
// Assumes a 32-bit register port with byte addresses on an 8-bit address.
package timer_module_pkg;

  // Widths of the counter halves and prescalers
  localparam int HALF_WIDTH = 16;
  localparam int PRESCALE_WIDTH = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_WIDTH_CONFIG = 8'h00;
  localparam logic [7:0] OFF_FIRST_MODE = 8'h04;
  localparam logic [7:0] OFF_SECOND_MODE = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h1c;
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h20;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h24;
  localparam logic [7:0] OFF_FIRST_LOAD = 8'h28;
  localparam logic [7:0] OFF_SECOND_LOAD = 8'h2c;
  localparam logic [7:0] OFF_FIRST_MATCH = 8'h30;
  localparam logic [7:0] OFF_FIRST_PRESCALE = 8'h38;
  localparam logic [7:0] OFF_SECOND_PRESCALE = 8'h3c;
  localparam logic [7:0] OFF_FIRST_COUNT = 8'h48;
  localparam logic [7:0] OFF_SECOND_COUNT = 8'h4c;

  // Width configuration codes
  localparam logic [2:0] CFG_JOINED_TIMER = 3'h0;
  localparam logic [2:0] CFG_JOINED_CLOCK = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;

  // Half mode field codes
  localparam logic [1:0] HALF_ONE_SHOT = 2'h1;
  localparam logic [1:0] HALF_PERIODIC = 2'h2;

  // Control register bit positions
  localparam int CTL_FIRST_ENABLE = 0;
  localparam int CTL_FIRST_STALL = 1;
  localparam int CTL_STALL_OVERRIDE = 4;
  localparam int CTL_FIRST_TRIGGER = 5;
  localparam int CTL_SECOND_ENABLE = 8;
  localparam int CTL_SECOND_STALL = 9;
  localparam int CTL_SECOND_TRIGGER = 13;

  // Status, mask and clear bit positions
  localparam int STS_FIRST_TIMEOUT = 0;
  localparam int STS_CLOCK_MATCH = 3;
  localparam int STS_SECOND_TIMEOUT = 8;

  // Reset and start values
  localparam logic [15:0] HALF_LOAD_RESET = 16'hffff;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [31:0] CLOCK_START = 32'h0000_0001;

  // Real-time clock input rate and tick rate, in Hz
  localparam int CLOCK_INPUT_HZ = 32768;
  localparam int CLOCK_TICK_HZ = 1;
  localparam int CLOCK_DIVIDE = CLOCK_INPUT_HZ / CLOCK_TICK_HZ;

  // Operating mode decoded from the width configuration
  typedef enum logic [1:0] {
    MODE_JOINED_TIMER = 2'b00,
    MODE_JOINED_CLOCK = 2'b01,
    MODE_SPLIT = 2'b10
  } width_mode_type;

endpackage

// ### timer_module_top.sv
// Dual-half general timer: two 16-bit halves, joined 32-bit one-shot or
// periodic down-counter, or 32-bit real-time clock fed by a slow pin clock.
// Assumes a one-cycle strobe register port and a debug halt level input.
//
// Behaviour
// - Two 16-bit halves, split or joined
// - Converter triggers ORed outside; enable one
// - Split halves use 8-bit prescaler
// - Reset: inactive, counts and loads 0xFFFF
// - Reset: prescale registers and counters zero
// - Config 0 joined timer, 1 clock
// - Config 0x4 gives split halves
// - Joined mode is one timer only
// - Joined load write fills both loads
// - Joined count read returns both halves
// - First mode field picks one-shot/periodic
// - Count down, reload after zero
// - One-shot stops and clears enable
// - Zero sets raw time-out until cleared
// - Unmasked time-out sets masked flag
// - Trigger pulse only when enabled
// - Load rewrite reloads running counter
// - Debug stall freezes count during halt
// - Clock counts up from one
// - Pin clock divided to 1 Hz
// - Match rolls clock over to zero
// - Match sets raw, masked, interrupt
// - Clear bit clears clock-match flags
// - Override keeps clock running in halt
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
module timer_module_top
  import timer_module_pkg::*;
#(
  parameter int DIVIDE = CLOCK_DIVIDE
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  // Debug and slow clock pin
  input wire logic i_debug_halt,
  input wire logic i_capture_pin_zero,
  // Events
  output logic o_interrupt,
  output logic o_converter_trigger
);

  typedef struct packed {
    logic [2:0] cfg;
    logic [1:0][1:0] mode;
    logic [1:0] en;
    logic [1:0] stall;
    logic [1:0] ote;
    logic override;
    logic [1:0] to_raw;
    logic [1:0] to_mask;
    logic clk_raw;
    logic clk_mask;
    logic [1:0][15:0] load;
    logic [1:0][15:0] count;
    logic [31:0] match;
    logic [1:0][7:0] pre;
    logic [31:0] rdata;
    logic irq;
    logic trig;
  } state_type;

  localparam state_type RESET_STATE = '{
    cfg: CFG_JOINED_TIMER, mode: '0, en: '0, stall: '0, ote: '0, override: 1'b0,
    to_raw: '0, to_mask: '0, clk_raw: 1'b0, clk_mask: 1'b0,
    load: {HALF_LOAD_RESET, HALF_LOAD_RESET}, count: {HALF_LOAD_RESET, HALF_LOAD_RESET},
    match: '0, pre: {PRESCALE_RESET, PRESCALE_RESET}, rdata: '0, irq: 1'b0, trig: 1'b0};

  state_type s_q;
  state_type s_d;

  width_mode_type mode;
  logic frozen_first;
  logic [1:0] half_run;
  logic [1:0] half_tick;
  logic [1:0] pre_write;
  logic second;
  logic [31:0] joined;
  logic [1:0] to_event;
  logic clk_event;

  // configuration decode; codes other than 0 and 1 act as split
  function automatic width_mode_type decode_cfg(input logic [2:0] cfg);
    case (cfg)
      CFG_JOINED_TIMER: decode_cfg = MODE_JOINED_TIMER;
      CFG_JOINED_CLOCK: decode_cfg = MODE_JOINED_CLOCK;
      default: decode_cfg = MODE_SPLIT;
    endcase
  endfunction

  function automatic logic is_timer_mode(input logic [1:0] m);
    is_timer_mode = (m == HALF_ONE_SHOT) || (m == HALF_PERIODIC);
  endfunction

  // Same layout for raw, mask and masked status words
  function automatic logic [31:0] pack_status(input logic [1:0] to, input logic clk);
    logic [31:0] w;
    w = '0;
    w[STS_FIRST_TIMEOUT] = to[0];
    w[STS_CLOCK_MATCH] = clk;
    w[STS_SECOND_TIMEOUT] = to[1];
    pack_status = w;
  endfunction

  assign mode = decode_cfg(s_q.cfg);
  assign joined = {s_q.count[1], s_q.count[0]};

  // halt freezes the first half unless the clock overrides it
  assign frozen_first = i_debug_halt & ((mode == MODE_JOINED_CLOCK) ?
    ((s_q.stall[0] | s_q.stall[1]) & ~s_q.override) : s_q.stall[0]);

  // prescalers step only in split one-shot or periodic halves
  assign half_run[0] = s_q.en[0] & ~frozen_first & (mode == MODE_SPLIT) &
    is_timer_mode(s_q.mode[0]);
  assign half_run[1] = s_q.en[1] & ~(i_debug_halt & s_q.stall[1]) &
    (mode == MODE_SPLIT) & is_timer_mode(s_q.mode[1]);
  assign pre_write[0] = i_write && (i_addr == OFF_FIRST_PRESCALE);
  assign pre_write[1] = i_write && (i_addr == OFF_SECOND_PRESCALE);

  // One prescaler per half
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pre
      half_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_pre (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_run(half_run[g]),
        .i_reload(pre_write[g]),
        .i_prescale(pre_write[g] ? i_wdata[7:0] : s_q.pre[g]), // Restart from the new value
        .o_tick(half_tick[g])
      );
    end
  endgenerate

  // slow pin clock runs the divider only while the clock is enabled
  clock_divider #(.DIVIDE(DIVIDE)) u_div (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run((mode == MODE_JOINED_CLOCK) && s_q.en[0]),
    .i_capture_pin_zero(i_capture_pin_zero),
    .o_second(second)
  );

  // Next state: counting first, then software writes, then flags and reads
  always_comb begin
    s_d = s_q;
    s_d.trig = 1'b0;
    s_d.rdata = '0;
    to_event = '0;
    clk_event = 1'b0;
    case (mode)
      MODE_JOINED_TIMER: begin
        // one joined down-counter, first mode field rules
        if (s_q.en[0] && !frozen_first) begin
          if (joined == '0) begin
            {s_d.count[1], s_d.count[0]} = {s_q.load[1], s_q.load[0]};
            to_event[0] = 1'b1;
            if (s_q.mode[0] == HALF_ONE_SHOT) begin
              s_d.en[0] = 1'b0;
            end
          end else begin
            {s_d.count[1], s_d.count[0]} = joined - 32'h1;
          end
        end
      end
      MODE_JOINED_CLOCK: begin
        // up-count once a second, roll to zero on match
        if (s_q.en[0] && !frozen_first && second) begin
          if (joined == s_q.match) begin
            {s_d.count[1], s_d.count[0]} = '0;
            clk_event = 1'b1;
          end else begin
            {s_d.count[1], s_d.count[0]} = joined + 32'h1;
          end
        end
      end
      MODE_SPLIT: begin
        // each half counts on its own prescaled step
        for (int n = 0; n < 2; n++) begin
          if (half_tick[n]) begin
            if (s_q.count[n] == '0) begin
              s_d.count[n] = s_q.load[n];
              to_event[n] = 1'b1;
              if (s_q.mode[n] == HALF_ONE_SHOT) begin
                s_d.en[n] = 1'b0;
              end
            end else begin
              s_d.count[n] = s_q.count[n] - 16'h1;
            end
          end
        end
      end
      default: begin
      end
    endcase

    // Software writes; a write in the same cycle wins over counting
    if (i_write) begin
      case (i_addr)
        OFF_WIDTH_CONFIG: begin
          s_d.cfg = i_wdata[2:0];
          // first entry to clock mode starts from one
          if (i_wdata[2:0] == CFG_JOINED_CLOCK && s_q.cfg != CFG_JOINED_CLOCK) begin
            {s_d.count[1], s_d.count[0]} = CLOCK_START;
          end
        end
        OFF_FIRST_MODE: s_d.mode[0] = i_wdata[1:0];
        OFF_SECOND_MODE: s_d.mode[1] = i_wdata[1:0];
        OFF_CONTROL: begin
          s_d.en[0] = i_wdata[CTL_FIRST_ENABLE];
          s_d.stall[0] = i_wdata[CTL_FIRST_STALL];
          s_d.override = i_wdata[CTL_STALL_OVERRIDE];
          s_d.ote[0] = i_wdata[CTL_FIRST_TRIGGER];
          s_d.en[1] = i_wdata[CTL_SECOND_ENABLE];
          s_d.stall[1] = i_wdata[CTL_SECOND_STALL];
          s_d.ote[1] = i_wdata[CTL_SECOND_TRIGGER];
        end
        OFF_INT_MASK: begin
          s_d.to_mask[0] = i_wdata[STS_FIRST_TIMEOUT];
          s_d.clk_mask = i_wdata[STS_CLOCK_MATCH];
          s_d.to_mask[1] = i_wdata[STS_SECOND_TIMEOUT];
        end
        OFF_FIRST_LOAD: begin
          s_d.load[0] = i_wdata[15:0];
          // joined write also fills the second load
          if (mode != MODE_SPLIT) begin
            s_d.load[1] = i_wdata[31:16];
          end
          // running counter takes the new load next cycle
          if (s_q.en[0] && mode == MODE_JOINED_TIMER) begin
            {s_d.count[1], s_d.count[0]} = i_wdata;
          end else if (s_q.en[0] && mode == MODE_SPLIT) begin
            s_d.count[0] = i_wdata[15:0];
          end
        end
        OFF_SECOND_LOAD: begin
          s_d.load[1] = i_wdata[15:0];
          if (s_q.en[1] && mode == MODE_SPLIT) begin
            s_d.count[1] = i_wdata[15:0];
          end
        end
        OFF_FIRST_MATCH: s_d.match = i_wdata;
        OFF_FIRST_PRESCALE: s_d.pre[0] = i_wdata[7:0];
        OFF_SECOND_PRESCALE: s_d.pre[1] = i_wdata[7:0];
        default: begin
        end
      endcase
    end

    // sticky flags; a new event wins over a clear in the same cycle
    if (i_write && i_addr == OFF_INT_CLEAR) begin
      s_d.to_raw[0] = s_q.to_raw[0] & ~i_wdata[STS_FIRST_TIMEOUT];
      s_d.to_raw[1] = s_q.to_raw[1] & ~i_wdata[STS_SECOND_TIMEOUT];
      s_d.clk_raw = s_q.clk_raw & ~i_wdata[STS_CLOCK_MATCH];
    end
    s_d.to_raw = s_d.to_raw | to_event;
    s_d.clk_raw = s_d.clk_raw | clk_event;

    // trigger pulse gated per half; the system ORs all blocks
    s_d.trig = |(to_event & s_q.ote);

    // interrupt tracks the masked flags of the next state
    s_d.irq = |(pack_status(s_d.to_raw, s_d.clk_raw) &
      pack_status(s_d.to_mask, s_d.clk_mask));

    // Read data stands one cycle after the strobe; unmapped reads give zero
    if (i_read) begin
      case (i_addr)
        OFF_WIDTH_CONFIG: s_d.rdata = {29'h0, s_q.cfg};
        OFF_FIRST_MODE: s_d.rdata = {30'h0, s_q.mode[0]};
        OFF_SECOND_MODE: s_d.rdata = {30'h0, s_q.mode[1]};
        OFF_CONTROL: begin
          s_d.rdata[CTL_FIRST_ENABLE] = s_q.en[0];
          s_d.rdata[CTL_FIRST_STALL] = s_q.stall[0];
          s_d.rdata[CTL_STALL_OVERRIDE] = s_q.override;
          s_d.rdata[CTL_FIRST_TRIGGER] = s_q.ote[0];
          s_d.rdata[CTL_SECOND_ENABLE] = s_q.en[1];
          s_d.rdata[CTL_SECOND_STALL] = s_q.stall[1];
          s_d.rdata[CTL_SECOND_TRIGGER] = s_q.ote[1];
        end
        OFF_INT_MASK: s_d.rdata = pack_status(s_q.to_mask, s_q.clk_mask);
        OFF_RAW_STATUS: s_d.rdata = pack_status(s_q.to_raw, s_q.clk_raw);
        OFF_MASKED_STATUS: s_d.rdata = pack_status(s_q.to_raw & s_q.to_mask,
          s_q.clk_raw & s_q.clk_mask);
        OFF_FIRST_LOAD: s_d.rdata = (mode != MODE_SPLIT) ?
          {s_q.load[1], s_q.load[0]} : {16'h0, s_q.load[0]};
        OFF_SECOND_LOAD: s_d.rdata = {16'h0, s_q.load[1]};
        OFF_FIRST_MATCH: s_d.rdata = s_q.match;
        OFF_FIRST_PRESCALE: s_d.rdata = {24'h0, s_q.pre[0]};
        OFF_SECOND_PRESCALE: s_d.rdata = {24'h0, s_q.pre[1]};
        OFF_FIRST_COUNT: s_d.rdata = (mode != MODE_SPLIT) ? joined : {16'h0, s_q.count[0]};
        OFF_SECOND_COUNT: s_d.rdata = {16'h0, s_q.count[1]};
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = s_q.rdata;
  assign o_interrupt = s_q.irq;
  assign o_converter_trigger = s_q.trig;

  // Checks on the design's own behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  property p_joined_read;
    (i_read && i_addr == OFF_FIRST_COUNT && mode != MODE_SPLIT) |=> (o_rdata == $past(joined));
  endproperty
  a_joined_read: assert property (p_joined_read) else $error("joined read wrong");

  property p_joined_load;
    (i_write && i_addr == OFF_FIRST_LOAD && mode != MODE_SPLIT)
      |=> ({s_q.load[1], s_q.load[0]} == $past(i_wdata));
  endproperty
  a_joined_load: assert property (p_joined_load) else $error("joined load wrong");

  property p_reload_at_zero;
    (mode == MODE_JOINED_TIMER && s_q.en[0] && !frozen_first && joined == '0 && !i_write)
      |=> (joined == $past({s_q.load[1], s_q.load[0]})) && s_q.to_raw[0];
  endproperty
  a_reload_at_zero: assert property (p_reload_at_zero) else $error("no reload at zero");

  property p_one_shot_stops;
    (to_event[0] && s_q.mode[0] == HALF_ONE_SHOT && !i_write) |=> !s_q.en[0];
  endproperty
  a_one_shot_stops: assert property (p_one_shot_stops) else $error("one-shot kept running");

  property p_flag_sticky;
    (s_q.to_raw[0] && !(i_write && i_addr == OFF_INT_CLEAR)) |=> s_q.to_raw[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("time-out flag lost");

  property p_irq_follows_mask;
    ($rose(s_q.to_raw[0]) && s_q.to_mask[0]) |-> o_interrupt;
  endproperty
  a_irq_follows_mask: assert property (p_irq_follows_mask) else $error("no interrupt");

  property p_trigger_gated;
    o_converter_trigger |-> $past(|(to_event & s_q.ote));
  endproperty
  a_trigger_gated: assert property (p_trigger_gated) else $error("stray trigger");

  property p_stall_freezes;
    (mode == MODE_JOINED_TIMER && i_debug_halt && s_q.stall[0] && !i_write) |=> $stable(joined);
  endproperty
  a_stall_freezes: assert property (p_stall_freezes) else $error("count moved in halt");

  property p_clock_rollover;
    clk_event && !i_write |=> (joined == '0) && s_q.clk_raw;
  endproperty
  a_clock_rollover: assert property (p_clock_rollover) else $error("no rollover");

  property p_clock_clear;
    (i_write && i_addr == OFF_INT_CLEAR && i_wdata[STS_CLOCK_MATCH] && !clk_event) |=> !s_q.clk_raw;
  endproperty
  a_clock_clear: assert property (p_clock_clear) else $error("clock flag not cleared");

endmodule
